// >>> hw/adc_port.v
// digital port of a four-input subranging sampling converter
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// the phase limit default below needs the constants before the header
`include "adc_port_defines.vh"

module adc_port #(
    parameter AIN_W         = 12,              // signed level width
    parameter PHASE_MAX_CYC = `PHASE_MAX_CYC   // longest clock phase
) (
    input  wire                    i_clk,
    input  wire                    i_rst_n,
    input  wire                    i_conv_clk,
    input  wire                    i_write_strobe_n,
    input  wire                    i_channel_select_hi,
    input  wire                    i_channel_select_lo,
    input  wire                    i_sleep_request,
    input  wire signed [AIN_W-1:0] i_analog_input_1,
    input  wire signed [AIN_W-1:0] i_analog_input_2,
    input  wire signed [AIN_W-1:0] i_analog_input_3,
    input  wire signed [AIN_W-1:0] i_analog_input_4,
    input  wire [3:0]              i_addr,
    input  wire [31:0]             i_wdata,
    input  wire                    i_wr,
    input  wire                    i_rd,
    output reg  [31:0]             o_rdata,
    output reg  [9:0]              o_result,
    output reg                     o_range_exceeded_flag,
    output reg                     o_low_power,
    output reg                     o_irq
);

    reg         conv_clk_q_r;   // previous level of the converter clock
    wire        conv_rise;      // sample ends here
    wire        conv_fall;      // high phase ends here
    reg  [1:0]  channel_r;      // held input selection
    reg  signed [AIN_W-1:0] sample_r;  // level captured at the rise
    reg  signed [AIN_W-1:0] selected;  // level on the routed input
    reg  [3:0]  coarse_r;       // coarse nibble, stage two
    reg  [5:0]  fine_r;         // fine bits, stage two
    reg         over_r;         // overflow, stage two
    reg  [1:0]  fill_r;         // pipeline occupancy
    wire [3:0]  coarse;
    wire [5:0]  fine;
    wire        over;
    reg  [`PHASE_CNT_W-1:0] phase_cnt_r;  // cycles in current phase
    reg         timing_bad;     // phase length out of bounds
    reg         ev_done;        // new result this cycle
    reg         ev_over;        // new result flagged overflow
    reg  [2:0]  status_r;       // sticky events
    reg  [2:0]  status_nxt;
    reg  [2:0]  mask_r;         // interrupt enables
    reg  [2:0]  clear_bits;     // write-one-to-clear request
    wire        frozen;

    localparam [`PHASE_CNT_W-1:0] HIGH_MIN = `HIGH_MIN_CYC;
    localparam [`PHASE_CNT_W-1:0] LOW_MIN  = `LOW_MIN_CYC;
    localparam [`PHASE_CNT_W-1:0] PHASE_MAX = PHASE_MAX_CYC;
    localparam [`PHASE_CNT_W-1:0] CNT_TOP  = {`PHASE_CNT_W{1'b1}};

    assign conv_rise = i_conv_clk & ~conv_clk_q_r;
    assign conv_fall = ~i_conv_clk & conv_clk_q_r;
    assign frozen    = i_sleep_request;

    // edge history of the converter clock pin
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            conv_clk_q_r <= 1'b0;
        else
            conv_clk_q_r <= i_conv_clk;
    end

    // selection follows the lines while the strobe is low
    // reset picks the first input, as the pulled-low lines would
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            channel_r <= `CHANNEL_RST;
        else if (!i_write_strobe_n)
            channel_r <= {i_channel_select_hi,
                          i_channel_select_lo};
    end

    // analog routing from the held selection
    always @*
    begin
        case (channel_r)
            2'b00:   selected = i_analog_input_1;
            2'b01:   selected = i_analog_input_2;
            2'b10:   selected = i_analog_input_3;
            default: selected = i_analog_input_4;
        endcase
    end

    subrange_encoder #(
        .AIN_W    (AIN_W)
    ) u_encoder (
        .i_level  (sample_r),
        .o_coarse (coarse),
        .o_fine   (fine),
        .o_over   (over)
    );

    // three-stage pipeline on converter clock rises
    // a new sample enters each rise; sleep stops every stage so
    // the outputs and the samples in flight are kept as they are
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            sample_r <= {AIN_W{1'b0}};
            coarse_r <= 4'h0;
            fine_r   <= 6'h00;
            over_r   <= 1'b0;
            fill_r   <= 2'b00;
            o_result <= `RESULT_RST;
            o_range_exceeded_flag <= 1'b0;
            ev_done  <= 1'b0;
            ev_over  <= 1'b0;
        end
        else
        begin
            ev_done <= 1'b0;
            ev_over <= 1'b0;
            if (conv_rise && !frozen)
            begin
                // level captured while the clock was low
                sample_r <= selected;
                // coarse and fine segments both registered at this same rise
                coarse_r <= coarse;
                fine_r   <= fine;
                over_r   <= over;
                fill_r   <= {fill_r[0], 1'b1};
                // straight binary word, msb at bit 9
                o_result <= {coarse_r, fine_r};
                // flag travels on its own, result bits untouched
                o_range_exceeded_flag <= over_r;
                ev_done <= fill_r[1];
                ev_over <= fill_r[1] & over_r;
            end
        end
    end

    // low-consumption indication follows the sleep request
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_low_power <= 1'b0;
        else
            o_low_power <= i_sleep_request;
    end

    // phase length watch; the host owns the clock, this only reports
    // a pulsed clock resting past the longest phase is reported too
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            phase_cnt_r <= {`PHASE_CNT_W{1'b0}};
        else if (conv_rise || conv_fall)
            phase_cnt_r <= {{(`PHASE_CNT_W-1){1'b0}}, 1'b1};
        else if (phase_cnt_r != CNT_TOP)
            phase_cnt_r <= phase_cnt_r + 1'b1;
    end

    // a phase is judged as it ends, or when it runs too long
    always @*
    begin
        timing_bad = 1'b0;
        if (conv_fall && (phase_cnt_r < HIGH_MIN))
            timing_bad = 1'b1;
        else if (conv_rise && (phase_cnt_r < LOW_MIN))
            timing_bad = 1'b1;
        else if (phase_cnt_r == PHASE_MAX)
            timing_bad = 1'b1;
    end

    // sticky events, a write of one clears; a new event wins
    always @*
    begin
        clear_bits = 3'h0;
        if (i_wr && (i_addr == `REG_EVENT_STATUS))
            clear_bits = i_wdata[2:0];
        status_nxt = status_r & ~clear_bits;
        status_nxt[`EV_DONE_BIT]   = status_nxt[`EV_DONE_BIT] | ev_done;
        status_nxt[`EV_OVER_BIT]   = status_nxt[`EV_OVER_BIT] | ev_over;
        status_nxt[`EV_TIMING_BIT] = status_nxt[`EV_TIMING_BIT]
                                     | timing_bad;
    end

    // status, mask and interrupt line
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            status_r <= `EVENT_STATUS_RST;
            mask_r   <= `EVENT_MASK_RST;
            o_irq    <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            if (i_wr && (i_addr == `REG_EVENT_MASK))
                mask_r <= i_wdata[2:0];
            // one cycle behind the status bit, kept on a flop
            o_irq <= |(status_r & mask_r);
        end
    end

    // read port, data in the cycle after the strobe only
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_rdata <= 32'h0000_0000;
        else if (!i_rd)
            o_rdata <= 32'h0000_0000;
        else if (i_addr == `REG_EVENT_STATUS)
            o_rdata <= {29'h0000_0000, status_r};
        else if (i_addr == `REG_EVENT_MASK)
            o_rdata <= {29'h0000_0000, mask_r};
        else if (i_addr == `REG_RESULT_VIEW)
            o_rdata <= {18'h0_0000, o_low_power, channel_r,
                        o_range_exceeded_flag, o_result};
        else
            o_rdata <= 32'h0000_0000;   // unmapped reads zero
    end

endmodule

`default_nettype wire

// >>> hw/adc_port_defines.vh
// constants for the four-input subranging converter digital port
// What this block does
// - strobe low routes selected input, else holds
// - undriven select lines default to first input
// - sleep request freezes result, enters low power
// - result appears two clock periods after sample
// - four coarse bits from fifteen comparators, six fine
// - below range gives zero, above gives full scale
// - separate overflow output at top of range
// - ten bit result, bit 9 most significant
// - sample while low, end at rising edge
// - overflow flag never alters the result bits
// - straight binary code, registered before the outputs
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// register byte offsets
`define REG_EVENT_STATUS  4'h0
`define REG_EVENT_MASK    4'h4
`define REG_RESULT_VIEW   4'h8

// event bit positions in status and mask
`define EV_DONE_BIT       0
`define EV_OVER_BIT       1
`define EV_TIMING_BIT     2
`define EV_W              3

// result view field positions
`define RV_FLAG_BIT       10
`define RV_CHAN_LSB       11
`define RV_SLEEP_BIT      13

// reset values
`define EVENT_STATUS_RST  3'h0
`define EVENT_MASK_RST    3'h0
`define CHANNEL_RST       2'h0
`define RESULT_RST        10'h000

// result format
`define RESULT_W          10
`define FULL_SCALE        10'h3ff
`define COARSE_W          4
`define FINE_W            6
`define COARSE_CMP        15

// timing, in ns and derived cycle counts
`define CLK_PERIOD_NS     10
`define HIGH_MIN_NS       250
`define LOW_MIN_NS        150
`define PHASE_MAX_NS      500000
`define HIGH_MIN_CYC  ((`HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_MIN_CYC   ((`LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_MAX_CYC (`PHASE_MAX_NS / `CLK_PERIOD_NS)
`define PHASE_CNT_W       20

`endif

// >>> hw/subrange_encoder.v
// coarse and fine segment encoder for one sampled level
`timescale 1ns/10ps
`default_nettype none

module subrange_encoder #(
    parameter AIN_W = 12
) (
    input  wire signed [AIN_W-1:0] i_level,
    output wire [3:0]              o_coarse,
    output wire [5:0]              o_fine,
    output wire                    o_over
);
    `include "adc_port_defines.vh"

    wire [9:0]  clamped;   // level forced into the code range
    wire [14:0] thermo;    // coarse comparator outputs

    // out of range levels pin to zero or full scale
    assign clamped = (i_level < 0) ? `RESULT_RST :
                     (i_level > $signed({2'b00, `FULL_SCALE})) ?
                     `FULL_SCALE : i_level[9:0];
    // overflow is decided apart from the clamped code
    assign o_over = (i_level >= $signed(12'sd1024));

    // fifteen coarse comparators at multiples of 64 codes
    genvar k;
    generate
        for (k = 1; k <= `COARSE_CMP; k = k + 1)
        begin : g_cmp
            // threshold nibble of this comparator, k never exceeds 15
            localparam [3:0] LEVEL = k;
            assign thermo[k-1] = (clamped[9:6] >= LEVEL);
        end
    endgenerate

    // count of tripped comparators is the upper nibble
    function [3:0] thermo_count;
        input [14:0] t;
        integer j;
        begin
            thermo_count = 4'h0;
            for (j = 0; j < 15; j = j + 1)
                thermo_count = thermo_count + {3'b000, t[j]};
        end
    endfunction

    assign o_coarse = thermo_count(thermo);
    // fine segment resolves the residue inside the coarse range
    assign o_fine   = clamped[5:0];

endmodule

`default_nettype wire

// >>> test/adc_port_assertions.sv
// concurrent checks on the converter port outputs
`timescale 1ns/10ps
`default_nettype none
module adc_port_checker (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_conv_clk,
    input wire logic        i_sleep_request,
    input wire logic [3:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [9:0]  o_result,
    input wire logic        o_range_exceeded_flag,
    input wire logic        o_low_power,
    input wire logic        o_irq
);
    // one clock domain, all checks quiet in reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_low_power_copy: assert property (
        $past(i_rst_n) |-> o_low_power == $past(i_sleep_request))
        else $error("low power output does not follow sleep request");
    a_sleep_freeze: assert property (
        i_sleep_request [*3] |=> $stable(o_result)
            && $stable(o_range_exceeded_flag))
        else $error("result moved during sleep");
    a_result_cause: assert property (
        $changed(o_result) |-> $past(i_conv_clk) && !$past(i_conv_clk, 2)
            && !$past(i_sleep_request))
        else $error("result changed without a converter clock rise");
    a_flag_full: assert property (
        o_range_exceeded_flag |-> o_result == 10'h3ff)
        else $error("overflow flag with a code below full scale");
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside the read answer cycle");
    a_view_result: assert property (
        $past(i_rd) && $past(i_addr) == 4'h8 && $stable(o_result)
            && $stable(o_range_exceeded_flag)
            |-> o_rdata[10:0] == {o_range_exceeded_flag, o_result})
        else $error("result view differs from result pins");
    a_unmapped_zero: assert property (
        $past(i_rd) && $past(i_addr) == 4'hc |-> o_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_mask_quiet: assert property (
        i_wr && i_addr == 4'h4 && i_wdata[2:0] == 3'h0 |=> ##1 !o_irq)
        else $error("interrupt stays high with all events masked");
endmodule
bind adc_port adc_port_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_conv_clk(i_conv_clk), .i_sleep_request(i_sleep_request),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_result(o_result), .o_low_power(o_low_power),
    .o_range_exceeded_flag(o_range_exceeded_flag), .o_irq(o_irq));
`default_nettype wire

// >>> test/host_clock_model.sv
// host side model: converter clock bursts with chosen phase lengths
`timescale 1ns/10ps
`default_nettype none
module host_clock_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [7:0]  i_n,
    input  wire logic [15:0] i_hi,
    input  wire logic [15:0] i_lo,
    output var  logic        o_conv_clk,
    output var  logic        o_busy
);
    int k; // rise counter within a burst
    initial
    begin
        o_conv_clk = 1'b0;
        o_busy = 1'b0;
    end
    // clock rests low between bursts, so pulsed use looks like a long sample
    always @(posedge i_clk)
    begin
        if (i_go && !o_busy)
        begin
            o_busy <= 1'b1;
            for (k = 0; k < i_n; k++)
            begin
                repeat (i_lo) @(posedge i_clk);
                o_conv_clk <= 1'b1;
                repeat (i_hi) @(posedge i_clk);
                o_conv_clk <= 1'b0;
            end
            o_busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> test/test_adc_port.sv
// self-checking bench for the converter port
`timescale 1ns/10ps
`default_nettype none
module test_adc_port;
    logic               i_clk = 1'b0;            // 100 MHz system clock
    logic               i_rst_n = 1'b0;          // sync reset, active low
    logic               i_write_strobe_n = 1'b0; // low: select follows
    logic               i_channel_select_hi = 1'b0;
    logic               i_channel_select_lo = 1'b0;
    logic               i_sleep_request = 1'b0;
    logic signed [11:0] ain [0:3];               // four input levels
    logic [3:0]         i_addr = 4'h0;
    logic [31:0]        i_wdata = 32'h0000_0000;
    logic               i_wr = 1'b0, i_rd = 1'b0, go = 1'b0;
    logic [31:0]        o_rdata, rd_val;
    logic [9:0]         o_result;
    logic               o_range_exceeded_flag, o_low_power, o_irq;
    logic               conv_clk, busy;
    logic [15:0]        hi_cyc = 16'h001a;       // just above legal minimum
    logic [7:0]         n_rise = 8'h03;
    int                 n_mismatch = 0, checks = 0;
    always #5 i_clk = ~i_clk;
    adc_port #(.AIN_W(12), .PHASE_MAX_CYC(200)) dut (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_conv_clk(conv_clk),
        .i_write_strobe_n(i_write_strobe_n),
        .i_channel_select_hi(i_channel_select_hi),
        .i_channel_select_lo(i_channel_select_lo),
        .i_sleep_request(i_sleep_request), .i_analog_input_1(ain[0]),
        .i_analog_input_2(ain[1]), .i_analog_input_3(ain[2]),
        .i_analog_input_4(ain[3]), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_result(o_result),
        .o_range_exceeded_flag(o_range_exceeded_flag),
        .o_low_power(o_low_power), .o_irq(o_irq));
    host_clock_model host (.i_clk(i_clk), .i_go(go), .i_n(n_rise),
        .i_hi(hi_cyc), .i_lo(16'h0010), .o_conv_clk(conv_clk), .o_busy(busy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask
    // n converter clock rises; waits bounded for the burst to finish
    task automatic conv(input logic [7:0] n, input logic [15:0] h);
        int k;
        @(posedge i_clk);
        go <= 1'b1;
        n_rise <= n;
        hi_cyc <= h;
        @(posedge i_clk);
        go <= 1'b0;
        #1 k = 0;
        while (busy === 1'b1 && k < 9000)
        begin
            @(posedge i_clk);
            #1 k++;
        end
        if (k == 9000)
        begin
            n_mismatch++;
            conclude();
        end
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    // strobe a select code, then scramble the lines with strobe high
    task automatic pick(input logic [1:0] c);
        @(posedge i_clk);
        i_write_strobe_n <= 1'b0;
        {i_channel_select_hi, i_channel_select_lo} <= c;
        repeat (2) @(posedge i_clk);
        i_write_strobe_n <= 1'b1;
        {i_channel_select_hi, i_channel_select_lo} <= ~c;
    endtask
    task automatic t_mux;
        conv(8'h03, 16'h001a);
        chk(o_result, ain[0][9:0]);
        for (int c = 0; c < 4; c++)
        begin
            pick(c[1:0]);
            conv(8'h03, 16'h001a);
            chk(o_result, ain[c][9:0]);
        end
        $display("test mux done");
    endtask
    // single rises: each result lags its sample by two rises
    task automatic t_pipe;
        logic [9:0] v [0:3] = '{10'h001, 10'h3c0, 10'h240, 10'h07f};
        pick(2'h0);
        for (int i = 0; i < 4; i++)
        begin
            ain[0] <= {2'b00, v[i]};
            conv(8'h01, 16'h001a);
            chk(o_result, (i < 2) ? ain[3][9:0] : v[i-2]);
        end
        $display("test pipeline done");
    endtask
    task automatic t_range;
        logic [11:0] lv [0:3] = '{12'hffb, 12'h3ff, 12'h400, 12'h7ff};
        logic [9:0]  code;
        pick(2'h1);
        for (int i = 0; i < 4; i++)
        begin
            ain[1] <= lv[i];
            conv(8'h03, 16'h001a);
            code = (i == 0) ? 10'h000 : 10'h3ff;
            chk(o_result, code);
            chk(o_range_exceeded_flag, i >= 2);
            reg_rd(4'h8);
            // awake, input 2 held, flag, then the code
            chk(rd_val, {18'h0_0000, 1'b0, 2'b01, i >= 2, code});
        end
        $display("test range done");
    endtask
    task automatic t_sleep;
        ain[1] <= 12'h155;
        conv(8'h03, 16'h001a);
        @(posedge i_clk);
        i_sleep_request <= 1'b1;
        ain[1] <= 12'h0aa;
        conv(8'h03, 16'h001a);
        chk(o_result, 10'h155);
        chk(o_low_power, 1'b1);
        @(posedge i_clk);
        i_sleep_request <= 1'b0;
        conv(8'h03, 16'h001a);
        chk(o_result, 10'h0aa);
        chk(o_low_power, 1'b0);
        $display("test sleep done");
    endtask
    task automatic t_irq;
        reg_wr(4'h0, 32'h0000_0007);
        reg_wr(4'h4, 32'h0000_0001);
        conv(8'h03, 16'h001a);
        chk(o_irq, 1'b1);
        reg_wr(4'h4, 32'h0000_0000);
        repeat (2) @(posedge i_clk);
        #1;
        chk(o_irq, 1'b0);
        reg_wr(4'h4, 32'h0000_0004);
        conv(8'h01, 16'h0005);
        reg_rd(4'h0);
        chk(rd_val[2], 1'b1);
        chk(o_irq, 1'b1);
        reg_wr(4'h0, 32'h0000_0007);
        reg_rd(4'hc);
        chk(rd_val, 32'h0000_0000);
        chk(o_irq, 1'b0);
        $display("test interrupt done");
    endtask
    initial
    begin
        ain[0] = 12'h0a5;
        ain[1] = 12'h15a;
        ain[2] = 12'h2c3;
        ain[3] = 12'h3f0;
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_mux();
        t_pipe();
        t_range();
        t_sleep();
        t_irq();
        conclude();
    end
endmodule
`default_nettype wire
